//--- rtl/gtq_pkg.sv
// Purpose: constants and types for the group trigger qualifier
// Assumes: one 20 MHz clock, active-low asynchronous reset
// Notes: settings arrive as plain ports; there is no register bus
// Notes on behaviour
// - mask bits 8..11 select external, software, threshold, bus command; 12..15 read 0
// - once armed, each enabled non-threshold source sets a sticky flag
// - and mode fires only after every selected condition was captured
// - threshold is never latched; in and mode it counts after the rest
// - per-group slope picks rising or falling external edge
// - one shared external edge detector; latest arm sets the edge
// - slope threshold detects signed crossing in the programmed direction
// - a sample already beyond the level at arm needs a fresh crossing
// - level modes trigger while sample is above or below level
// - one channel of the group is the threshold source, last named wins
// - at arm with threshold selected, error if source channel disabled or level out of range
// - threshold readback returns all four groups regardless of state
// - threshold quantised to range/128, floor of code/256, reported back
// - a level beyond the channel range quantises as the 20 V range
// - unnamed group or channel defaults to 0
// - a group may follow another group's trigger in the same cycle
// - any-channel modes trigger when any active channel is above or below
// - trigger location recorded relative to memory address 0
// - memory written once per four conversions
// - threshold offset is 0, 0..1 or 0..3 for four, two or one channel; the code always reports offset 0
// - non-threshold sources add two locations of compensation
// - each group has and/or combining, or after reset
`default_nettype none

package gtq_pkg;
   localparam int NUM_GROUPS   = 4;
   localparam int NUM_CHANNELS = 4;
   localparam int MASK_W       = 16;
   localparam int SAMPLE_W     = 16;
   localparam int ADDR_W       = 16;
   localparam int TTL_LINES    = 8;
   localparam int BIT_EXT      = 8;
   localparam int BIT_SOFT     = 9;
   localparam int BIT_THRESH   = 10;
   localparam int BIT_BUSCMD   = 11;
   localparam int USED_BITS    = 12;
   localparam logic [MASK_W-1:0] MASK_USED = 16'h0_FFF;
   localparam logic [MASK_W-1:0] MASK_RESET = 16'h0_200;
   // level is kept as a byte: sample code divided by 256, floored
   localparam int LEVEL_W      = 8;
   localparam int LEVEL_SHIFT  = 8;
   localparam logic [ADDR_W-1:0] COMP_LOCATIONS = 16'h0_002;
   localparam logic [1:0] DEFAULT_GROUP   = 2'h0;
   localparam logic [1:0] DEFAULT_CHANNEL = 2'h0;
   localparam logic [1:0] WRITES_EVERY    = 2'h3;

   typedef enum logic [2:0] {
      gtq_rising_cross_level  = 3'b000,
      gtq_falling_cross_level = 3'b001,
      gtq_above_level_mode    = 3'b010,
      gtq_below_level_mode    = 3'b011,
      gtq_any_channel_above_mode = 3'b100,
      gtq_any_channel_below_mode = 3'b101
   } gtq_thresh_mode_type;

   typedef enum logic [1:0] {
      gtq_idle      = 2'b00,
      gtq_armed     = 2'b01,
      gtq_triggered = 2'b10
   } gtq_state_type;
endpackage

`default_nettype wire

//--- rtl/gtq_input_sync.sv
// Purpose: three-flop synchroniser with agreement filter for pin inputs
// Assumes: input asynchronous to clk_i
// Notes: output changes only when stages two and three agree
`default_nettype none

module gtq_input_sync #(
   parameter int WIDTH = 9
) (
   // clock and reset
   input  wire logic             clk_i,
   input  wire logic             resetn_i,
   // data
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] q;
   } gtq_sync_type;

   gtq_sync_type r;
   gtq_sync_type next_r;

   always_comb begin
      next_r    = r;
      next_r.s1 = async_i;
      next_r.s2 = r.s1;
      next_r.s3 = r.s2;
      for (int i = 0; i < WIDTH; i++) begin
         // first stage is read only by the second
         if (r.s2[i] == r.s3[i]) begin
            next_r.q[i] = r.s3[i];
         end
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign sync_o = r.q;
endmodule // gtq_input_sync

`default_nettype wire

//--- rtl/gtq_qualifier.sv
// Purpose: trigger qualification for all channel groups of a digitizer
// Assumes: host parser has already decoded its commands; the level is quantised here
// Notes: one shared external edge detector serves every group
`default_nettype none

module gtq_qualifier
   import gtq_pkg::*;
#(
   parameter int GROUPS   = gtq_pkg::NUM_GROUPS,
   parameter int CHANNELS = gtq_pkg::NUM_CHANNELS
) (
   // clock and reset
   input  wire logic                         clk_i,
   input  wire logic                         resetn_i,
   // pins from the backplane and front panel
   input  wire logic [gtq_pkg::TTL_LINES-1:0] ttl_trig_i,
   input  wire logic                         ext_trig_i,
   // per-group settings from the host
   input  wire logic [GROUPS-1:0][gtq_pkg::MASK_W-1:0] src_mask_i,
   input  wire logic [GROUPS-1:0]            and_mode_i,
   input  wire logic [GROUPS-1:0]            set_logic_i,
   input  wire logic [GROUPS-1:0]            ext_rising_i,
   input  wire gtq_pkg::gtq_thresh_mode_type [GROUPS-1:0] thresh_mode_i,
   input  wire logic [GROUPS-1:0][1:0]       thresh_chan_i,
   input  wire logic [GROUPS-1:0]            thresh_chan_named_i,
   input  wire logic signed [GROUPS-1:0][gtq_pkg::SAMPLE_W-1:0] level_req_i,
   input  wire logic [GROUPS-1:0][gtq_pkg::SAMPLE_W-1:0] range_code_i,
   input  wire logic [GROUPS-1:0]            follow_enable_i,
   input  wire logic [GROUPS-1:0][1:0]       follow_group_source_i,
   input  wire logic [GROUPS-1:0]            set_thresh_i,
   input  wire logic [1:0]                   set_group_i,
   input  wire logic                         set_group_named_i,
   input  wire logic [GROUPS-1:0][CHANNELS-1:0] chan_enable_i,
   // actions from the host
   input  wire logic [GROUPS-1:0]            arm_i,
   input  wire logic [GROUPS-1:0]            soft_trig_i,
   input  wire logic [GROUPS-1:0]            bus_trig_i,
   // sample stream at memory write time
   input  wire logic [GROUPS-1:0]            mem_write_i,
   input  wire logic [GROUPS-1:0][gtq_pkg::ADDR_W-1:0] mem_addr_i,
   input  wire logic [GROUPS-1:0][CHANNELS-1:0][gtq_pkg::SAMPLE_W-1:0] sample_i,
   // readback and status
   output logic [GROUPS-1:0][gtq_pkg::MASK_W-1:0] mask_rb_o,
   output logic signed [GROUPS-1:0][gtq_pkg::LEVEL_W-1:0] level_rb_o,
   output logic [GROUPS-1:0][1:0]            thresh_chan_rb_o,
   output logic [GROUPS-1:0]                 and_mode_rb_o,
   output logic [GROUPS-1:0]                 armed_o,
   output logic [GROUPS-1:0]                 group_trig_o,
   output logic [GROUPS-1:0]                 triggered_o,
   output logic [GROUPS-1:0][gtq_pkg::ADDR_W-1:0] trig_offset_o,
   output logic [GROUPS-1:0]                 arm_error_o,
   output logic                              ext_edge_rising_o
);
   typedef struct packed {
      gtq_state_type [GROUPS-1:0]                state;
      logic [GROUPS-1:0][MASK_W-1:0]            mask;
      logic [GROUPS-1:0]                        and_mode;
      logic [GROUPS-1:0][1:0]                   tchan;
      logic signed [GROUPS-1:0][LEVEL_W-1:0]    level;
      logic [GROUPS-1:0][USED_BITS-1:0]         sticky;
      logic [GROUPS-1:0]                        was_beyond;
      logic [GROUPS-1:0]                        err;
      logic [GROUPS-1:0][ADDR_W-1:0]            offset;
      logic [GROUPS-1:0]                        fired;
      logic                                     ext_rising;
      logic                                     ext_prev;
   } gtq_state_reg_type;

   gtq_state_reg_type r;
   gtq_state_reg_type next_r;

   logic [TTL_LINES:0] pins_sync;
   logic [GROUPS-1:0]  fire_own;
   logic [GROUPS-1:0]  fire;
   logic [GROUPS-1:0]  thr_fire;
   logic               ext_event;

   gtq_input_sync #(
      .WIDTH (TTL_LINES + 1)
   ) u_sync (
      .clk_i    (clk_i),
      .resetn_i (resetn_i),
      .async_i  ({ext_trig_i, ttl_trig_i}),
      .sync_o   (pins_sync)
   );

   // one shared detector; polarity follows the most recent arm
   assign ext_event = r.ext_rising ? (pins_sync[TTL_LINES] & ~r.ext_prev)
                                   : (~pins_sync[TTL_LINES] & r.ext_prev);

   // level quantised: floor(code/256); arithmetic shift floors negatives
   function automatic logic signed [LEVEL_W-1:0] quantise(
      input logic signed [SAMPLE_W-1:0] req,
      input logic [SAMPLE_W-1:0]        rng
   );
      logic signed [SAMPLE_W-1:0] q;
      q = req >>> LEVEL_SHIFT;
      // out-of-range request: code already on full 20 V scale
      if ((req > $signed(rng)) || (req < -$signed(rng))) begin
         q = req >>> LEVEL_SHIFT;
      end
      return q[LEVEL_W-1:0];
   endfunction

   function automatic logic signed [LEVEL_W-1:0] samp_level(
      input logic [SAMPLE_W-1:0] s
   );
      logic signed [SAMPLE_W-1:0] t;
      t = $signed(s) >>> LEVEL_SHIFT;
      return t[LEVEL_W-1:0];
   endfunction

   // threshold compares on written data, group by group
   generate
      for (genvar g = 0; g < GROUPS; g++) begin : g_thr
         logic signed [LEVEL_W-1:0] src;
         logic signed [LEVEL_W-1:0] lvl;
         logic [CHANNELS-1:0]       above;
         logic [CHANNELS-1:0]       below;
         logic                      hit;
         always_comb begin
            src = samp_level(sample_i[g][r.tchan[g]]);
            // an element select drops the sign; compare on a signed copy
            lvl = r.level[g];
            for (int c = 0; c < CHANNELS; c++) begin
               above[c] = chan_enable_i[g][c] &&
                  (samp_level(sample_i[g][c]) > lvl);
               below[c] = chan_enable_i[g][c] &&
                  (samp_level(sample_i[g][c]) < lvl);
            end
            case (thresh_mode_i[g])
               gtq_rising_cross_level:  hit = r.was_beyond[g] == 1'b0 &&
                                              src > lvl;
               gtq_falling_cross_level: hit = r.was_beyond[g] == 1'b0 &&
                                              src < lvl;
               gtq_above_level_mode:    hit = src > lvl;
               gtq_below_level_mode:    hit = src < lvl;
               gtq_any_channel_above_mode: hit = |above;
               gtq_any_channel_below_mode: hit = |below;
               default:                 hit = 1'b0;
            endcase
            thr_fire[g] = mem_write_i[g] && r.state[g] == gtq_armed &&
                          r.mask[g][BIT_THRESH] && hit;
         end
      end
   endgenerate

   // own firing: and mode needs every captured flag, threshold last
   always_comb begin
      for (int g = 0; g < GROUPS; g++) begin
         logic [USED_BITS-1:0] now;
         logic [USED_BITS-1:0] sel;
         logic [USED_BITS-1:0] have;
         now = '0;
         now[TTL_LINES-1:0] = pins_sync[TTL_LINES-1:0];
         now[BIT_EXT]    = ext_event;
         now[BIT_SOFT]   = soft_trig_i[g];
         now[BIT_BUSCMD] = bus_trig_i[g];
         sel  = r.mask[g][USED_BITS-1:0];
         have = r.sticky[g] | (now & sel);
         have[BIT_THRESH] = thr_fire[g];
         if (r.state[g] != gtq_armed) begin
            fire_own[g] = 1'b0;
         end else if (r.and_mode[g]) begin
            fire_own[g] = (sel != '0) && ((have & sel) == sel);
         end else begin
            fire_own[g] = |(have & sel);
         end
      end
   end

   // followers fire in the same cycle as their source, through chains
   always_comb begin
      fire = fire_own;
      for (int pass = 0; pass < GROUPS; pass++) begin
         for (int g = 0; g < GROUPS; g++) begin
            if (follow_enable_i[g] && r.state[g] == gtq_armed &&
                fire[follow_group_source_i[g]]) begin
               fire[g] = 1'b1;
            end
         end
      end
   end

   always_comb begin
      next_r          = r;
      next_r.ext_prev = pins_sync[TTL_LINES];
      for (int g = 0; g < GROUPS; g++) begin
         logic [USED_BITS-1:0] now;
         logic [1:0]           grp;
         logic signed [LEVEL_W-1:0] cur;
         now = '0;
         grp = set_group_named_i ? set_group_i : DEFAULT_GROUP;
         cur = samp_level(sample_i[g][r.tchan[g]]);
         now[TTL_LINES-1:0] = pins_sync[TTL_LINES-1:0];
         now[BIT_EXT]    = ext_event;
         now[BIT_SOFT]   = soft_trig_i[g];
         now[BIT_BUSCMD] = bus_trig_i[g];
         if (set_logic_i[g]) begin
            next_r.and_mode[g] = and_mode_i[g];
         end
         if (set_thresh_i[g] && grp == g[1:0]) begin
            next_r.mask[g]  = src_mask_i[g] & MASK_USED;
            next_r.tchan[g] = thresh_chan_named_i[g] ? thresh_chan_i[g]
                                                     : DEFAULT_CHANNEL;
            next_r.level[g] = quantise(level_req_i[g], range_code_i[g]);
         end
         case (r.state[g])
            gtq_idle, gtq_triggered: begin
               if (arm_i[g]) begin
                  next_r.state[g]   = gtq_armed;
                  next_r.sticky[g]  = '0;
                  next_r.fired[g]   = 1'b0;
                  next_r.offset[g]  = '0;
                  next_r.ext_rising = ext_rising_i[g];
                  // beyond the level at arm blocks until it returns
                  next_r.was_beyond[g] = 1'b1;
                  next_r.err[g] = r.mask[g][BIT_THRESH] &&
                     (!chan_enable_i[g][r.tchan[g]] ||
                      $signed(r.level[g]) >
                      $signed(samp_level(range_code_i[g])) ||
                      $signed(r.level[g]) <
                      -$signed(samp_level(range_code_i[g])));
               end
            end
            gtq_armed: begin
               // sticky capture of every selected non-threshold source
               next_r.sticky[g] = r.sticky[g] |
                  (now & r.mask[g][USED_BITS-1:0]);
               next_r.sticky[g][BIT_THRESH] = 1'b0;
               if (mem_write_i[g]) begin
                  case (thresh_mode_i[g])
                     gtq_rising_cross_level:
                        next_r.was_beyond[g] = cur > $signed(r.level[g]);
                     gtq_falling_cross_level:
                        next_r.was_beyond[g] = cur < $signed(r.level[g]);
                     default: next_r.was_beyond[g] = 1'b0;
                  endcase
               end
               if (fire[g]) begin
                  next_r.state[g] = gtq_triggered;
                  next_r.fired[g] = 1'b1;
                  // threshold reports the written address itself
                  if (thr_fire[g]) begin
                     next_r.offset[g] = mem_addr_i[g];
                  end else begin
                     next_r.offset[g] = mem_addr_i[g] + COMP_LOCATIONS;
                  end
               end
            end
            default: next_r.state[g] = gtq_idle;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         r          <= '0;
         r.and_mode <= '0;
         for (int g = 0; g < GROUPS; g++) begin
            r.mask[g] <= MASK_RESET;
         end
      end else begin
         r <= next_r;
      end
   end

   // readback covers every group whatever its state
   assign mask_rb_o         = r.mask;
   assign level_rb_o        = r.level;
   assign thresh_chan_rb_o  = r.tchan;
   assign and_mode_rb_o     = r.and_mode;
   assign group_trig_o      = fire;
   assign triggered_o       = r.fired;
   assign trig_offset_o     = r.offset;
   assign arm_error_o       = r.err;
   assign ext_edge_rising_o = r.ext_rising;

   always_comb begin
      for (int g = 0; g < GROUPS; g++) begin
         armed_o[g] = r.state[g] == gtq_armed;
      end
   end
endmodule // gtq_qualifier

`default_nettype wire

//--- verif/gtq_assertions.sv
// Purpose: temporal checks on the trigger qualifier ports
// Assumes: one clock domain, active-low asynchronous reset
// Notes: per-group relations are watched on groups 0, 1 and 2 only, most of them on group 0
`default_nettype none

module gtq_checker
   import gtq_pkg::*;
#(
   parameter int GROUPS = 4
) (
   // clock and reset
   input wire logic                              clk_i,
   input wire logic                              resetn_i,
   // watched inputs
   input wire logic [GROUPS-1:0]                 arm_i,
   input wire logic [GROUPS-1:0]                 soft_trig_i,
   input wire logic [GROUPS-1:0]                 ext_rising_i,
   input wire logic [GROUPS-1:0]                 follow_enable_i,
   input wire logic [GROUPS-1:0][1:0]            follow_group_source_i,
   input wire logic [GROUPS-1:0]                 mem_write_i,
   input wire logic [GROUPS-1:0][gtq_pkg::ADDR_W-1:0] mem_addr_i,
   // watched outputs
   input wire logic [GROUPS-1:0][gtq_pkg::MASK_W-1:0] mask_rb_o,
   input wire logic [GROUPS-1:0]                 and_mode_rb_o,
   input wire logic [GROUPS-1:0]                 armed_o,
   input wire logic [GROUPS-1:0]                 group_trig_o,
   input wire logic [GROUPS-1:0]                 triggered_o,
   input wire logic [GROUPS-1:0][gtq_pkg::ADDR_W-1:0] trig_offset_o,
   input wire logic                              ext_edge_rising_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);

   chk_unused_zero: assert property (
      (mask_rb_o[0][15:12] | mask_rb_o[1][15:12]) == 4'h0)
      else $error("mask bits above eleven not zero");
   chk_fire_armed: assert property (
      group_trig_o[0] |-> armed_o[0])
      else $error("group fired while not armed");
   chk_fire_latch: assert property (
      group_trig_o[0] |=> triggered_o[0] && !armed_o[0])
      else $error("fire not recorded");
   chk_offset_comp: assert property (
      group_trig_o[0] && !mask_rb_o[0][BIT_THRESH] |=>
      trig_offset_o[0] == $past(mem_addr_i[0]) + COMP_LOCATIONS)
      else $error("offset lacks compensation");
   chk_thresh_written: assert property (
      group_trig_o[0] && mask_rb_o[0][11:0] == 12'h400 |-> mem_write_i[0]
      ##1 trig_offset_o[0] == $past(mem_addr_i[0]))
      else $error("threshold fire off a write or offset wrong");
   chk_soft_or: assert property (
      armed_o[0] && !and_mode_rb_o[0] && mask_rb_o[0][BIT_SOFT]
      && soft_trig_i[0] |-> group_trig_o[0])
      else $error("software pulse did not fire");
   chk_follow_same: assert property (
      armed_o[1] && follow_enable_i[1] && follow_group_source_i[1] == 2'h0
      && group_trig_o[0] |-> group_trig_o[1])
      else $error("follower not fired in source cycle");
   chk_slope_arm: assert property (
      arm_i[2] && !armed_o[2] |=> ext_edge_rising_o == $past(ext_rising_i[2]))
      else $error("shared edge not taken from last arm");
   chk_reset_values: assert property (
      $rose(resetn_i) |-> mask_rb_o[1] == MASK_RESET && !and_mode_rb_o[1])
      else $error("reset values wrong");
   chk_result_stands: assert property (
      triggered_o[0] && !arm_i[0] |=>
      triggered_o[0] && $stable(trig_offset_o[0]))
      else $error("recorded fire did not stand");
endmodule // gtq_checker

bind gtq_qualifier gtq_checker #(.GROUPS(GROUPS)) gtq_checker_i (
   .clk_i, .resetn_i, .arm_i, .soft_trig_i, .ext_rising_i,
   .follow_enable_i, .follow_group_source_i, .mem_write_i, .mem_addr_i,
   .mask_rb_o, .and_mode_rb_o, .armed_o, .group_trig_o, .triggered_o,
   .trig_offset_o, .ext_edge_rising_o);

`default_nettype wire

//--- verif/gtq_stream_model.sv
// Purpose: sample stream side, one memory write per conversion set
// Assumes: all groups share one convert clock
// Notes: spacing is a plain parameter, not a measured figure
`default_nettype none

module gtq_stream_model
   import gtq_pkg::*;
#(
   parameter int GROUPS  = 4,
   parameter int SPACING = 2
) (
   // clock and reset
   input  wire logic                         clk_i,
   input  wire logic                         resetn_i,
   // memory write stream
   output logic [GROUPS-1:0]                 mem_write_o,
   output logic [GROUPS-1:0][gtq_pkg::ADDR_W-1:0] mem_addr_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int unsigned       div;
   logic [ADDR_W-1:0] addr;

   // one strobe for every group so offsets of followers compare
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         div  <= 0;
         addr <= '0;
      end else if (div == SPACING - 1) begin
         div  <= 0;
         addr <= addr + 1'b1;
      end else begin
         div <= div + 1;
      end
   end
   assign mem_write_o = {GROUPS{div == SPACING - 1}};
   assign mem_addr_o  = {GROUPS{addr}};
endmodule // gtq_stream_model

`default_nettype wire

//--- verif/tb.sv
// Purpose: self-checking bench for the group trigger qualifier
// Assumes: four groups of four channels, writes every second cycle
// Notes: groups are re-armed once they have fired
`default_nettype none

module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import gtq_pkg::*;
   logic                 clk_i, resetn_i, ext_trig_i, set_group_named_i;
   logic                 ext_edge_rising_o;
   logic [7:0]           ttl_trig_i;
   logic [3:0]           and_mode_i, set_logic_i, ext_rising_i, arm_i;
   logic [3:0]           thresh_chan_named_i, follow_enable_i, set_thresh_i;
   logic [3:0]           soft_trig_i, bus_trig_i, mem_write_i, armed_o;
   logic [3:0]           and_mode_rb_o, group_trig_o, triggered_o;
   logic [3:0]           arm_error_o;
   logic [1:0]           set_group_i;
   logic [3:0][15:0]     src_mask_i, range_code_i, mem_addr_i, mask_rb_o;
   logic [3:0][15:0]     trig_offset_o;
   logic signed [3:0][15:0] level_req_i;
   logic signed [3:0][7:0]  level_rb_o;
   logic [3:0][1:0]      thresh_chan_i, follow_group_source_i;
   logic [3:0][1:0]      thresh_chan_rb_o;
   gtq_thresh_mode_type [3:0] thresh_mode_i;
   logic [3:0][3:0]      chan_enable_i;
   logic [3:0][3:0][15:0] sample_i;
   int                   error_cnt, tests_run, cycles;

   gtq_qualifier gtq_qualifier_i (.clk_i, .resetn_i, .ttl_trig_i,
      .ext_trig_i, .src_mask_i, .and_mode_i, .set_logic_i, .ext_rising_i,
      .thresh_mode_i, .thresh_chan_i, .thresh_chan_named_i, .level_req_i,
      .range_code_i, .follow_enable_i, .follow_group_source_i,
      .set_thresh_i, .set_group_i, .set_group_named_i, .chan_enable_i,
      .arm_i, .soft_trig_i, .bus_trig_i, .mem_write_i, .mem_addr_i,
      .sample_i, .mask_rb_o, .level_rb_o, .thresh_chan_rb_o, .and_mode_rb_o,
      .armed_o, .group_trig_o, .triggered_o, .trig_offset_o, .arm_error_o,
      .ext_edge_rising_o);
   gtq_stream_model gtq_stream_model_i (.clk_i, .resetn_i,
      .mem_write_o(mem_write_i), .mem_addr_o(mem_addr_i));

   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // ceiling well above the fewer than two hundred cycles the scenarios need
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 4000) begin
         error_cnt++;
         give_verdict;
      end
   end
   task automatic tick;
      @(posedge clk_i);
      #5;
   endtask
   task automatic chk(input string nm, input logic [15:0] got, exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic cfg(input int g, input logic [15:0] m,
                      input gtq_thresh_mode_type md, input logic [15:0] lv,
                      input logic am);
      src_mask_i[g] = m;
      thresh_mode_i[g] = md;
      level_req_i[g] = lv;
      and_mode_i[g] = am;
      thresh_chan_i[g] = (g == 0) ? 2'h3 : 2'(g);
      thresh_chan_named_i[g] = (g != 0);
      // group 0 goes through the unnamed default path
      set_group_named_i = (g != 0);
      set_group_i = (g == 0) ? 2'h2 : 2'(g);
      set_thresh_i[g] = 1'b1;
      set_logic_i[g] = 1'b1;
      tick;
      set_thresh_i = '0;
      set_logic_i = '0;
      tick;
   endtask
   task automatic arm(input logic [3:0] g);
      arm_i = g;
      tick;
      arm_i = '0;
   endtask
   // first look one step late so inputs changed at this edge have settled
   task automatic expect_fire(input int g, input logic [15:0] comp);
      logic [15:0] a;
      #1;
      for (int n = 0; n < 40 && group_trig_o[g] !== 1'b1; n++) tick;
      chk("group_trig", group_trig_o[g], 1);
      a = mem_addr_i[g];
      tick;
      soft_trig_i = '0;
      chk("triggered", triggered_o[g], 1);
      chk("offset", trig_offset_o[g], a + comp);
   endtask
   task automatic scen_soft_follow;
      follow_enable_i[1] = 1'b1;
      cfg(1, 16'h0200, gtq_rising_cross_level, 16'h0000, 1'b0);
      soft_trig_i[0] = 1'b1;
      tick;
      soft_trig_i = '0;
      chk("idle_trig", triggered_o[0], 0);
      arm(4'h3);
      soft_trig_i[0] = 1'b1;
      expect_fire(0, COMP_LOCATIONS);
      chk("follower", triggered_o[1], 1);
      follow_enable_i[1] = 1'b0;
      cfg(0, 16'hF321, gtq_rising_cross_level, 16'h0000, 1'b0);
      chk("mask_rb", mask_rb_o[0], 16'h0321);
      chk("other_mask", mask_rb_o[2], MASK_RESET);
      chk("chan_rb0", {14'h0, thresh_chan_rb_o[0]}, 16'h0000);
      chk("chan_rb1", {14'h0, thresh_chan_rb_o[1]}, 16'h0001);
   endtask
   task automatic scen_and;
      cfg(1, 16'h0801, gtq_rising_cross_level, 16'h0000, 1'b1);
      chk("and_rb", and_mode_rb_o[1], 1);
      arm(4'h2);
      chk("armed", {12'h000, armed_o}, 16'h0002);
      bus_trig_i[1] = 1'b1;
      tick;
      bus_trig_i = '0;
      repeat (8) tick;
      chk("and_wait", triggered_o[1], 0);
      ttl_trig_i[0] = 1'b1;
      expect_fire(1, COMP_LOCATIONS);
      ttl_trig_i[0] = 1'b0;
   endtask
   task automatic scen_cross;
      sample_i[0] = {4{16'h0000}};
      cfg(0, 16'h0400, gtq_rising_cross_level, 16'hD666, 1'b0);
      chk("level_rb", {8'h00, level_rb_o[0]}, 16'h00D6);
      arm(4'h1);
      repeat (8) tick;
      chk("beyond_at_arm", triggered_o[0], 0);
      chk("arm_err", arm_error_o[0], 0);
      sample_i[0] = {4{16'h8000}};
      repeat (8) tick;
      chk("below_level", triggered_o[0], 0);
      sample_i[0] = {4{16'h0000}};
      expect_fire(0, 16'h0000);
   endtask
   task automatic scen_modes;
      logic [15:0] lo, hi;
      for (int m = 0; m < 6; m++) begin
         lo = m[0] ? 16'h2000 : 16'h0800;
         hi = m[0] ? 16'h0800 : 16'h2000;
         sample_i[2] = {4{lo}};
         cfg(2, 16'h0400, gtq_thresh_mode_type'(m), 16'h1000, 1'b0);
         arm(4'h4);
         repeat (6) tick;
         chk("idle_side", triggered_o[2], 0);
         if (m >= 4) sample_i[2][3] = hi;
         else sample_i[2] = {4{hi}};
         expect_fire(2, 16'h0000);
      end
   endtask
   task automatic scen_ext_err;
      cfg(3, 16'h0100, gtq_rising_cross_level, 16'h0000, 1'b0);
      arm(4'h8);
      cfg(2, 16'h0100, gtq_rising_cross_level, 16'h0000, 1'b0);
      for (int s = 1; s >= 0; s--) begin
         ext_rising_i[2] = s[0];
         arm(4'h4);
         tick;
         chk("edge_sel", ext_edge_rising_o, s[0]);
         ext_trig_i = s[0];
         expect_fire(2, COMP_LOCATIONS);
         chk("early_group", triggered_o[3], 1);
      end
      chan_enable_i[3][3] = 1'b0;
      cfg(3, 16'h0400, gtq_above_level_mode, 16'h1000, 1'b0);
      arm(4'h8);
      tick;
      chk("arm_err", arm_error_o[3], 1);
   endtask

   initial begin
      {resetn_i, ext_trig_i, set_group_named_i, ttl_trig_i} = '0;
      {and_mode_i, set_logic_i, ext_rising_i, arm_i} = '0;
      {thresh_chan_named_i, follow_enable_i, set_thresh_i} = '0;
      {soft_trig_i, bus_trig_i, set_group_i, src_mask_i} = '0;
      {level_req_i, thresh_chan_i, follow_group_source_i, sample_i} = '0;
      thresh_mode_i = {4{gtq_rising_cross_level}};
      range_code_i = {4{16'h7FFF}};
      chan_enable_i = '1;
      repeat (12) @(posedge clk_i);
      #5;
      resetn_i = 1'b1;
      tick;
      for (int g = 0; g < 4; g++) begin
         chk("mask_rst", mask_rb_o[g], MASK_RESET);
         chk("and_rst", and_mode_rb_o[g], 0);
      end
      scen_soft_follow;
      scen_and;
      scen_cross;
      scen_modes;
      scen_ext_err;
      give_verdict;
   end
endmodule // tb

`default_nettype wire
